// File: hw/i2cst_core.sv
// slave transmitter core: address match, byte send, status and hold
`timescale 1ns/1ps
`default_nettype none
`include "i2cst_defines.svh"

// Operation
// - enter slave transmit only on own address with read direction bit 1
// - own address plus read sets service flag and a valid status code
// - status A8 after own address read received and acknowledged
// - arbitration lost in address phase then addressed for read gives B0
// - data byte sent and acknowledged by master gives status B8
// - byte loaded with ack return 0 is sent as last, ack then sampled
// - byte loaded with ack return 1 is sent, ack sampled, more expected
// - last byte gives C0 on master not-ack, C8 on master ack
// - terminal exit with ack return 0: not addressed, no recognition
// - start request on terminal exit sends START once the bus is free
// - after the last byte, further master reads see released data line
// - ack return 0 ignores addresses, bus still watched, resume any time
// - status reads F8 whenever the service flag is clear
module i2cst_core (
    input  wire logic              core_clk,
    input  wire logic              rst_n,
    input  wire logic              scl_i,
    output logic                   scl_o,
    output logic                   scl_oe,
    input  wire logic              sda_i,
    output logic                   sda_o,
    output logic                   sda_oe,
    input  wire logic [6:0]        own_peer_id,
    input  wire logic              gen_call_enable,
    input  wire logic              ack_return_enable,
    input  wire logic              bus_begin_request,
    input  wire logic              halt_condition_request,
    input  wire logic [7:0]        byte_buffer_reg,
    input  wire logic              byte_load,
    input  wire logic              srv_flag_clear,
    input  wire logic              arb_lost_addr,
    output logic                   srv_flag,
    output i2cst_pkg::i2cst_status_t status_code,
    output logic                   slave_tx_active,
    output logic                   gen_call_hit,
    output logic                   start_launch,
    output logic                   bus_busy
);
    import i2cst_pkg::*;

    i2cst_line_if line ();

    i2cst_state_t  state_q;
    i2cst_status_t status_q;
    logic [7:0]    data_q;
    logic [7:0]    shift_q;
    logic [3:0]    bit_cnt_q;
    logic          si_q;
    logic          last_q;
    logic          acked_q;
    logic          arb_q;
    logic          busy_q;
    logic          start_pend_q;
    logic          gc_hit_q;
    logic          sda_drive;
    logic          addr_ok;
    logic          gc_ok;
    logic          si_set;
    logic          release_hold;

    i2cst_pin_sync u_sync (
        .core_clk (core_clk),
        .rst_n    (rst_n),
        .scl_i    (scl_i),
        .sda_i    (sda_i),
        .line     (line)
    );

    // status after a transmitted byte from ack and last-byte flag
    function automatic i2cst_status_t byte_status(input logic ack,
                                                  input logic last);
        if (!ack)
            byte_status = `I2CST_ST_DATA_NACK;
        else if (last)
            byte_status = `I2CST_ST_LAST_ACK;
        else
            byte_status = `I2CST_ST_DATA_ACK;
    endfunction

    // a clock fall that is not part of a start or stop
    function automatic logic clean_fall(input logic fall,
                                        input logic st,
                                        input logic sp);
        clean_fall = fall && !st && !sp;
    endfunction

    // address byte fully shifted in
    function automatic logic addr_full(input logic [3:0] cnt);
        addr_full = (cnt == `I2CST_BITS_PER_BYTE);
    endfunction

    // own address with read bit, only while ack return is set
    assign addr_ok = ack_return_enable
                   && (shift_q[7:1] == own_peer_id)
                   && (shift_q[0] == `I2CST_DIR_READ);
    // general call only with ack return and the enable bit
    assign gc_ok   = ack_return_enable && gen_call_enable
                   && (shift_q[7:1] == `I2CST_GC_ADDR)
                   && (shift_q[0] != `I2CST_DIR_READ);

    // the flag rises at the falling clock that closes an ack bit
    assign si_set = clean_fall(line.scl_fall, line.start_det, line.stop_det)
                 && ((state_q == ST_ADDR_ACK) || (state_q == ST_TX_ACK));
    // the held clock is released only while the stop request is low
    assign release_hold = si_q && srv_flag_clear && !si_set
                       && !halt_condition_request;

    // main sequence
    always_ff @(posedge core_clk) begin
        if (!rst_n) begin
            state_q <= ST_IDLE;
        end else if (line.start_det) begin
            state_q <= ST_ADDR;
        end else if (line.stop_det) begin
            state_q <= ST_IDLE;
        end else begin
            unique case (state_q)
                ST_IDLE: begin
                    state_q <= ST_IDLE;
                end
                ST_ADDR: begin
                    if (line.scl_fall && addr_full(bit_cnt_q))
                        state_q <= addr_ok ? ST_ADDR_ACK : ST_IDLE;
                end
                ST_ADDR_ACK: begin
                    if (line.scl_fall)
                        state_q <= ST_HOLD;
                end
                ST_HOLD: begin
                    if (release_hold)
                        state_q <= ST_SEND;
                end
                ST_SEND: begin
                    if (line.scl_fall && bit_cnt_q[2:0] == `I2CST_LAST_BIT)
                        state_q <= ST_TX_ACK;
                end
                ST_TX_ACK: begin
                    if (line.scl_fall)
                        state_q <= (acked_q && !last_q) ? ST_HOLD
                                                        : ST_TERM;
                end
                ST_TERM: begin
                    if (release_hold)
                        state_q <= ST_IDLE;
                end
                default: begin
                    state_q <= ST_IDLE;
                end
            endcase
        end
    end

    // address shift, transmit shift and bit counter
    always_ff @(posedge core_clk) begin
        if (!rst_n) begin
            shift_q   <= `I2CST_RST_BYTE;
            bit_cnt_q <= 4'h0;
        end else if (line.start_det || line.stop_det) begin
            bit_cnt_q <= 4'h0;
        end else if (state_q == ST_ADDR && line.scl_rise
                     && !addr_full(bit_cnt_q)) begin
            shift_q   <= {shift_q[6:0], line.sda};
            bit_cnt_q <= bit_cnt_q + 4'h1;
        end else if (state_q == ST_HOLD && release_hold) begin
            shift_q   <= data_q;
            bit_cnt_q <= 4'h0;
        end else if (state_q == ST_SEND && line.scl_fall) begin
            shift_q   <= {shift_q[6:0], 1'b1};
            bit_cnt_q <= bit_cnt_q + 4'h1;
        end
    end

    // byte buffer written by software at any time
    always_ff @(posedge core_clk) begin
        if (!rst_n)
            data_q <= `I2CST_RST_BYTE;
        else if (byte_load)
            data_q <= byte_buffer_reg;
    end

    // last-byte flag taken from ack return when the byte is released
    always_ff @(posedge core_clk) begin
        if (!rst_n)
            last_q <= 1'b0;
        else if (state_q == ST_HOLD && release_hold)
            last_q <= !ack_return_enable;
    end

    // master acknowledge sampled on the rising clock of the ack bit
    always_ff @(posedge core_clk) begin
        if (!rst_n)
            acked_q <= 1'b0;
        else if (state_q == ST_TX_ACK && line.scl_rise)
            acked_q <= !line.sda;
    end

    // arbitration loss remembered until a stop or the next hold state
    always_ff @(posedge core_clk) begin
        if (!rst_n)
            arb_q <= 1'b0;
        else if (arb_lost_addr)
            arb_q <= 1'b1;
        else if (line.stop_det || state_q == ST_HOLD)
            arb_q <= 1'b0;
    end

    // service flag: a set wins over a clear in the same cycle
    always_ff @(posedge core_clk) begin
        if (!rst_n)
            si_q <= 1'b0;
        else if (si_set)
            si_q <= 1'b1;
        else if (release_hold || line.stop_det || (srv_flag_clear && !si_q))
            si_q <= 1'b0;
    end

    // status code held with the flag
    always_ff @(posedge core_clk) begin
        if (!rst_n)
            status_q <= `I2CST_RST_STATUS;
        else if (si_set && state_q == ST_ADDR_ACK)
            status_q <= arb_q ? `I2CST_ST_ARB_READ
                              : `I2CST_ST_OWN_READ;
        else if (si_set)
            status_q <= byte_status(acked_q, last_q);
        else if (release_hold || line.stop_det)
            status_q <= `I2CST_ST_IDLE;
    end

    // bus busy between start and stop
    always_ff @(posedge core_clk) begin
        if (!rst_n)
            busy_q <= 1'b0;
        else if (line.start_det)
            busy_q <= 1'b1;
        else if (line.stop_det)
            busy_q <= 1'b0;
    end

    // pending start request raised on terminal exit, launched when free
    always_ff @(posedge core_clk) begin
        if (!rst_n)
            start_pend_q <= 1'b0;
        else if (state_q == ST_TERM && release_hold && bus_begin_request)
            start_pend_q <= 1'b1;
        else if (!busy_q && !line.start_det)
            start_pend_q <= 1'b0;
    end

    // general call seen, handed to the receiving side
    always_ff @(posedge core_clk) begin
        if (!rst_n)
            gc_hit_q <= 1'b0;
        else
            gc_hit_q <= state_q == ST_ADDR
                     && clean_fall(line.scl_fall, line.start_det,
                                   line.stop_det)
                     && addr_full(bit_cnt_q) && gc_ok;
    end

    // open-drain drive: low only, released elsewhere
    assign sda_o  = 1'b0;
    assign scl_o  = 1'b0;
    // data pulled low for the address ack and for zero bits of a byte
    always_comb begin
        sda_drive = 1'b0;
        case (state_q)
            ST_ADDR_ACK: sda_drive = 1'b1;
            ST_SEND:     sda_drive = !shift_q[7];
            default:     sda_drive = 1'b0;
        endcase
    end
    assign sda_oe = sda_drive;
    assign scl_oe = si_q;

    assign srv_flag        = si_q;
    assign status_code     = status_q;
    assign slave_tx_active = (state_q != ST_IDLE) && (state_q != ST_ADDR);
    assign gen_call_hit    = gc_hit_q;
    assign start_launch    = start_pend_q && !busy_q;
    assign bus_busy        = busy_q;
endmodule

`default_nettype wire

// File: hw/i2cst_defines.svh
// constants for the slave transmitter: status codes, widths, bus values
`ifndef I2CST_DEFINES_SVH
`define I2CST_DEFINES_SVH

`define I2CST_ST_OWN_READ    8'hA8
`define I2CST_ST_ARB_READ    8'hB0
`define I2CST_ST_DATA_ACK    8'hB8
`define I2CST_ST_DATA_NACK   8'hC0
`define I2CST_ST_LAST_ACK    8'hC8
`define I2CST_ST_IDLE        8'hF8

`define I2CST_DIR_READ       1'b1
`define I2CST_GC_ADDR        7'h00
`define I2CST_BITS_PER_BYTE  4'h8
`define I2CST_LAST_BIT       3'h7
`define I2CST_RST_STATUS     8'hF8
`define I2CST_RST_BYTE       8'h00

`endif

// File: hw/i2cst_pkg.sv
// types shared by the slave transmitter modules
package i2cst_pkg;

    typedef logic [7:0] i2cst_status_t;

    typedef enum logic [2:0] {
        ST_IDLE,
        ST_ADDR,
        ST_ADDR_ACK,
        ST_HOLD,
        ST_SEND,
        ST_TX_ACK,
        ST_TERM
    } i2cst_state_t;

endpackage

// File: hw/i2cst_line_if.sv
// synchronised bus line levels and events between sampler and core
`timescale 1ns/1ps
`default_nettype none

interface i2cst_line_if;
    logic scl;
    logic sda;
    logic scl_rise;
    logic scl_fall;
    logic start_det;
    logic stop_det;

    modport src (
        output scl, sda, scl_rise, scl_fall, start_det, stop_det
    );
    modport dst (
        input  scl, sda, scl_rise, scl_fall, start_det, stop_det
    );
endinterface

`default_nettype wire

// File: hw/i2cst_pin_sync.sv
// two-flop sampling of the bus lines and edge, start and stop detection
`timescale 1ns/1ps
`default_nettype none

module i2cst_pin_sync (
    input  wire logic    core_clk,
    input  wire logic    rst_n,
    input  wire logic    scl_i,
    input  wire logic    sda_i,
    i2cst_line_if.src    line
);
    logic [1:0] pin_in;
    logic [1:0] meta_q;
    logic [1:0] sync_q;
    logic [1:0] prev_q;

    assign pin_in = {scl_i, sda_i};

    // one synchroniser per line, idle lines read high
    genvar g;
    generate
        for (g = 0; g < 2; g++) begin : g_sync
            always_ff @(posedge core_clk) begin
                if (!rst_n) begin
                    meta_q[g] <= 1'b1;
                    sync_q[g] <= 1'b1;
                    prev_q[g] <= 1'b1;
                end else begin
                    meta_q[g] <= pin_in[g];
                    sync_q[g] <= meta_q[g];
                    prev_q[g] <= sync_q[g];
                end
            end
        end
    endgenerate

    assign line.scl       = sync_q[1];
    assign line.sda       = sync_q[0];
    assign line.scl_rise  = sync_q[1] & ~prev_q[1];
    assign line.scl_fall  = ~sync_q[1] & prev_q[1];
    assign line.start_det = sync_q[1] & prev_q[1] & ~sync_q[0] & prev_q[0];
    assign line.stop_det  = sync_q[1] & prev_q[1] & sync_q[0] & ~prev_q[0];
endmodule

`default_nettype wire

// File: sim/i2cst_core_sva.sv
// port assertions for the slave transmitter core
`timescale 1ns/1ps
`default_nettype none
module i2cst_core_sva
    import i2cst_pkg::*;
(
    input wire logic          core_clk,
    input wire logic          rst_n,
    input wire logic          scl_oe,
    input wire logic          sda_oe,
    input wire logic          ack_return_enable,
    input wire logic          gen_call_enable,
    input wire logic          halt_condition_request,
    input wire logic          srv_flag_clear,
    input wire logic          srv_flag,
    input wire i2cst_status_t status_code,
    input wire logic          slave_tx_active,
    input wire logic          gen_call_hit,
    input wire logic          start_launch,
    input wire logic          bus_busy
);
    default clocking cb @(posedge core_clk); endclocking
    default disable iff (!rst_n);
    sequence s_clear;
        srv_flag && srv_flag_clear && !halt_condition_request;
    endsequence
    sequence s_freed; !srv_flag ##[0:1] !scl_oe; endsequence
    property p_idle; !srv_flag |-> status_code == 8'hF8; endproperty
    a_idle: assert property (p_idle) else $error("status not idle");
    property p_codes;
        srv_flag |-> status_code inside {8'hA8, 8'hB0, 8'hB8, 8'hC0, 8'hC8};
    endproperty
    a_codes: assert property (p_codes) else $error("bad status");
    property p_hold;
        srv_flag ##1 srv_flag |-> scl_oe && $stable(status_code);
    endproperty
    a_hold: assert property (p_hold) else $error("clock not held");
    property p_free; s_clear |=> s_freed; endproperty
    a_free: assert property (p_free) else $error("clock not freed");
    property p_halt;
        srv_flag && halt_condition_request |=> srv_flag;
    endproperty
    a_halt: assert property (p_halt) else $error("flag cleared");
    property p_quiet;
        !ack_return_enable && !slave_tx_active && !srv_flag |-> !sda_oe;
    endproperty
    a_quiet: assert property (p_quiet) else $error("data driven");
    property p_gc;
        gen_call_hit |-> gen_call_enable && ack_return_enable;
    endproperty
    a_gc: assert property (p_gc) else $error("general call hit");
    property p_launch; $rose(start_launch) |-> !bus_busy; endproperty
    a_launch: assert property (p_launch) else $error("start on busy");
endmodule
bind i2cst_core i2cst_core_sva i2cst_core_sva_i (
    .core_clk, .rst_n, .scl_oe, .sda_oe, .ack_return_enable,
    .gen_call_enable, .halt_condition_request, .srv_flag_clear, .srv_flag,
    .status_code, .slave_tx_active, .gen_call_hit, .start_launch, .bus_busy
);
`default_nettype wire

// File: sim/i2cst_mrx.sv
// behavioural master receiver on the open-drain bus lines
`timescale 1ns/1ps
`default_nettype none
module i2cst_mrx (
    input  wire logic core_clk,
    input  wire logic scl,
    input  wire logic sda,
    output var logic  scl_low,
    output var logic  sda_low
);
    initial begin
        scl_low = 1'b0;
        sda_low = 1'b0;
    end
    task automatic q;
        repeat (2) @(posedge core_clk);
    endtask
    // release the clock and wait out a stretch by the slave of up to 4000 cycles
    task automatic rise;
        scl_low <= 1'b0;
        for (int i = 0; i < 4000 && scl !== 1'b1; i++) @(posedge core_clk);
        q();
    endtask
    task automatic slot(input logic b, output logic r);
        sda_low <= !b;
        q();
        rise();
        r = sda;
        q();
        scl_low <= 1'b1;
        q();
    endtask
    // s high gives a start, low a stop
    task automatic cond(input logic s);
        sda_low <= !s;
        q();
        rise();
        sda_low <= s;
        q();
        scl_low <= s;
        q();
    endtask
    task automatic frame(input logic [8:0] tx, output logic [8:0] rx);
        for (int i = 8; i >= 0; i--) slot(tx[i], rx[i]);
    endtask
endmodule
`default_nettype wire

// File: sim/i2c_slave_transmitter_bench.sv
// self-checking bench for the slave transmitter core
`timescale 1ns/1ps
`default_nettype none
module i2c_slave_transmitter_bench;
    import i2cst_pkg::*;
    localparam logic [6:0] OWN_ID = 7'h5A;
    logic core_clk = 1'b0, rst_n = 1'b0, gen_call_enable = 1'b0;
    logic ack_return_enable = 1'b1, bus_begin_request = 1'b0;
    logic halt_condition_request = 1'b0, byte_load = 1'b0;
    logic srv_flag_clear = 1'b0, arb_lost_addr = 1'b0;
    logic gc_seen = 1'b0, sl_seen = 1'b0;
    logic [7:0] byte_buffer_reg = 8'h00;
    logic [6:0] own_id = 7'h5A;
    logic [8:0] rx;
    logic scl_i, sda_i, scl_oe, sda_oe, m_scl, m_sda;
    logic srv_flag, slave_tx_active, gen_call_hit, start_launch, bus_busy;
    i2cst_status_t status_code;
    int n_fail = 0, compares = 0, cycles = 0;
    assign scl_i = !(scl_oe | m_scl);
    assign sda_i = !(sda_oe | m_sda);
    always #50 core_clk = !core_clk;
    always @(posedge core_clk) if (gen_call_hit === 1'b1) gc_seen <= 1'b1;
    always @(posedge core_clk) if (start_launch === 1'b1) sl_seen <= 1'b1;
    always @(posedge core_clk) begin
        cycles <= cycles + 1;
        if (cycles == 20000) begin
            n_fail++;
            stop_test();
        end
    end
    i2cst_core i2cst_core_i (
        .core_clk, .rst_n, .scl_i, .scl_o(), .scl_oe, .sda_i, .sda_o(),
        .sda_oe, .own_peer_id(own_id), .gen_call_enable, .ack_return_enable,
        .bus_begin_request, .halt_condition_request, .byte_buffer_reg,
        .byte_load, .srv_flag_clear, .arb_lost_addr, .srv_flag, .status_code,
        .slave_tx_active, .gen_call_hit, .start_launch, .bus_busy
    );
    i2cst_mrx i2cst_mrx_i (.core_clk, .scl(scl_i), .sda(sda_i),
        .scl_low(m_scl), .sda_low(m_sda));
    task automatic chk(string n, logic [7:0] e, logic [7:0] g);
        compares++;
        if (g !== e) begin
            n_fail++;
            $display("[FAIL] %s expected %h seen %h", n, e, g);
        end
    endtask
    task automatic chkb(string n, logic e, logic g);
        chk(n, {7'h00, e}, {7'h00, g});
    endtask
    task automatic wflag;
        for (int i = 0; i < 40 && srv_flag !== 1'b1; i++) @(posedge core_clk);
    endtask
    task automatic addr(logic [7:0] b);
        i2cst_mrx_i.cond(1'b1);
        i2cst_mrx_i.frame({b, 1'b1}, rx);
    endtask
    task automatic svc(logic [7:0] d, logic a);
        byte_buffer_reg <= d;
        byte_load <= 1'b1;
        ack_return_enable <= a;
        @(posedge core_clk);
        byte_load <= 1'b0;
        srv_flag_clear <= 1'b1;
        @(posedge core_clk);
        srv_flag_clear <= 1'b0;
        @(posedge core_clk);
    endtask
    task automatic rd(logic [7:0] e, logic ack, logic [7:0] st);
        i2cst_mrx_i.frame({8'hFF, !ack}, rx);
        chk("read byte", e, rx[8:1]);
        wflag();
        chk("status", st, status_code);
    endtask
    task automatic t_refuse;
        gen_call_enable <= 1'b1;
        addr(8'h00);
        chkb("gen call", 1'b1, gc_seen);
        addr({OWN_ID, 1'b0});
        chkb("write nak", 1'b1, rx[0]);
        addr({OWN_ID ^ 7'h01, 1'b1});
        chkb("other nak", 1'b1, rx[0]);
        own_id <= 7'h21;
        addr({OWN_ID, 1'b1});
        chkb("moved nak", 1'b1, rx[0]);
        own_id <= OWN_ID;
        i2cst_mrx_i.cond(1'b0);
    endtask
    task automatic t_stream;
        addr({OWN_ID, 1'b1});
        chkb("addr nak", 1'b0, rx[0]);
        wflag();
        chk("status", 8'hA8, status_code);
        chkb("active", 1'b1, slave_tx_active);
        svc(8'hA5, 1'b1);
        rd(8'hA5, 1'b1, 8'hB8);
        svc(8'h3C, 1'b0);
        rd(8'h3C, 1'b0, 8'hC0);
        svc(8'h00, 1'b0);
        rd(8'hFF, 1'b1, 8'hF8);
        i2cst_mrx_i.cond(1'b0);
    endtask
    task automatic t_last;
        addr({OWN_ID, 1'b1});
        chkb("off nak", 1'b1, rx[0]);
        i2cst_mrx_i.cond(1'b0);
        ack_return_enable <= 1'b1;
        addr({OWN_ID, 1'b1});
        chkb("on nak", 1'b0, rx[0]);
        wflag();
        svc(8'hC3, 1'b0);
        rd(8'hC3, 1'b1, 8'hC8);
        svc(8'h00, 1'b1);
        i2cst_mrx_i.cond(1'b0);
    endtask
    task automatic t_arb_start;
        arb_lost_addr <= 1'b1;
        @(posedge core_clk);
        arb_lost_addr <= 1'b0;
        addr({OWN_ID, 1'b1});
        wflag();
        chk("status", 8'hB0, status_code);
        halt_condition_request <= 1'b1;
        svc(8'h5A, 1'b1);
        chkb("held clock", 1'b1, scl_oe);
        halt_condition_request <= 1'b0;
        svc(8'h5A, 1'b0);
        rd(8'h5A, 1'b0, 8'hC0);
        bus_begin_request <= 1'b1;
        svc(8'h00, 1'b1);
        chkb("early start", 1'b0, sl_seen);
        chkb("busy", 1'b1, bus_busy);
        i2cst_mrx_i.cond(1'b0);
        repeat (10) @(posedge core_clk);
        chkb("start", 1'b1, sl_seen);
        chkb("free", 1'b0, bus_busy);
        bus_begin_request <= 1'b0;
    endtask
    task automatic stop_test;
        $display("compares %0d n_fail %0d", compares, n_fail);
        if (n_fail == 0 && compares > 0) $display("verification passed");
        else $display("verification failed");
        $finish;
    endtask
    initial begin
        repeat (2) @(posedge core_clk);
        rst_n <= 1'b1;
        repeat (2) @(posedge core_clk);
        chk("status", 8'hF8, status_code);
        t_refuse();
        t_stream();
        t_last();
        t_arb_start();
        stop_test();
    end
endmodule
`default_nettype wire
